/* File: design/msp_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte offsets inside one node window)
// ----------------------------------------------------------------
`define MSP_OFS_PROC_ID      8'h00
`define MSP_OFS_LOGICAL_ID   8'h04
`define MSP_OFS_PARTNER_ID   8'h08
`define MSP_OFS_STATE        8'h0c
`define MSP_OFS_DEVICE_ID    8'h10
`define MSP_OFS_TEST_REPORT  8'h14
`define MSP_OFS_PROCESSOR_UNIT_CLEAR_COMMAND     8'h18
`define MSP_OFS_MESSAGE      8'h1c

// ----------------------------------------------------------------
// Address fields and state bits
// ----------------------------------------------------------------
`define MSP_NODE_HI          15
`define MSP_NODE_LO          8
`define MSP_STATE_MARRIED    0
`define MSP_STATE_SHADOW     1
`define MSP_STATE_ACTIVE     2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MSP_RST_ID           8'h00
`define MSP_RST_WORD         32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MSP_CLK_PERIOD_NS    10
`define MSP_CLEAR_TIME_NS    100
`define MSP_CLEAR_CYCLES     ((`MSP_CLEAR_TIME_NS + `MSP_CLK_PERIOD_NS - 1) / `MSP_CLK_PERIOD_NS)

`endif

/* File: design/msp_pkg.sv */
// Types shared by the pairing control block
package msp_pkg;

  typedef logic [7:0]  msp_id_t;
  typedef logic [31:0] msp_word_t;

  // Memory access sequencer, one-hot
  typedef enum logic [2:0] {
    MSP_IDLE  = 3'b001,
    MSP_ISSUE = 3'b010,
    MSP_WAIT  = 3'b100
  } msp_seq_t;

endpackage : msp_pkg

/* File: design/msp_rb_if.sv */
// Carrier between the sequencer and the retry buffer
`timescale 1ns/1ps
`default_nettype none

interface msp_rb_if;
  logic              load;
  msp_pkg::msp_word_t addr_in;
  logic              wr_in;
  msp_pkg::msp_word_t wdata_in;
  msp_pkg::msp_word_t addr;
  logic              wr;
  msp_pkg::msp_word_t wdata;

  modport owner (output load, output addr_in, output wr_in, output wdata_in,
                 input addr, input wr, input wdata);
  modport store (input load, input addr_in, input wr_in, input wdata_in,
                 output addr, output wr, output wdata);
endinterface : msp_rb_if

`default_nettype wire

/* File: design/msp_retry_buf.sv */
// Retry buffer holding one processor request
`timescale 1ns/1ps
`default_nettype none
`include "msp_defs.svh"

module msp_retry_buf (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  msp_rb_if.store   rb
);

  // ----------------------------------------------------------------
  // Capture on load, hold otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rb.addr  <= `MSP_RST_WORD;
      rb.wr    <= 1'b0;
      rb.wdata <= `MSP_RST_WORD;
    end else if (rb.load) begin
      rb.addr  <= rb.addr_in;
      rb.wr    <= rb.wr_in;
      rb.wdata <= rb.wdata_in;
    end
  end

  // Content stands still unless a new load arrives
  a_buf_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !rb.load |=> $stable(rb.addr) && $stable(rb.wr) && $stable(rb.wdata))
    else $error("retry buffer changed without load");

endmodule : msp_retry_buf

`default_nettype wire

/* File: design/msp_top.sv */
// Shadow pairing and retry control of a processor bus interface unit
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "msp_defs.svh"

module msp_top #(
  parameter msp_pkg::msp_id_t PHYS_ID = 8'h01 // Arbitrary value
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // AHB-Lite register slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Processor request side
  input  wire logic        proc_req_i,
  input  wire logic [31:0] proc_addr_i,
  input  wire logic        proc_wr_i,
  input  wire logic [31:0] proc_wdata_i,
  output logic             proc_ready_o,
  output logic             proc_done_o,
  output logic [31:0]      proc_rdata_o,
  output logic             processor_clear_output_o,
  output logic [7:0]       proc_id_o,
  output logic             proc_id_load_o,
  // Interprocessor messages
  input  wire logic        ipc_valid_i,
  input  wire logic [7:0]  ipc_target_i,
  input  wire logic        ipc_startup_i,
  output logic             ipc_accept_o,
  // Memory bus
  output logic             bus_req_o,
  output logic [7:0]       bus_arb_id_o,
  output logic [31:0]      bus_addr_o,
  output logic             bus_wr_o,
  output logic [31:0]      bus_wdata_o,
  output logic             bus_oe_o,
  input  wire logic        bus_grant_i,
  input  wire logic        bus_done_i,
  input  wire logic        bus_err_i,
  input  wire logic [31:0] bus_rdata_i,
  // System-wide retry line
  input  wire logic        retry_all_i,
  output logic             retry_all_o
);

  msp_pkg::msp_seq_t  seq;
  msp_pkg::msp_id_t   proc_id;
  msp_pkg::msp_id_t   logical_id;
  msp_pkg::msp_id_t   partner_id;
  logic               married;
  logic               shadow;
  logic               active;
  logic               msg_pend;
  logic               rd_pend;
  logic               wr_pend;
  logic [7:0]         ap_ofs;
  logic               ap_hit;
  logic [3:0]         clr_cnt;
  logic               rs1;
  logic               rs2;
  logic               rs3;
  logic               rlvl;
  logic               retry_evt;
  logic               test_wr;
  logic               clear_wr;
  logic               state_wr;
  logic               msg_wr;
  logic               ap_take;
  logic               reissue;
  msp_rb_if           rb ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Node match against the identifier in force
  function automatic logic node_hit(input logic [31:0] a, input logic m,
                                    input msp_pkg::msp_id_t lid);
    node_hit = (a[`MSP_NODE_HI:`MSP_NODE_LO] == (m ? lid : PHYS_ID));
  endfunction : node_hit

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign ap_take = hsel_i && htrans_i[1] && hready_i;
  assign hresp_o = 1'b0;
  assign hreadyout_o = !rd_pend;

  // Address phase capture; reads get one wait state
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      ap_ofs  <= 8'h00;
      ap_hit  <= 1'b0;
    end else begin
      rd_pend <= ap_take && !hwrite_i;
      wr_pend <= ap_take && hwrite_i;
      if (ap_take) begin
        ap_ofs <= haddr_i[7:0];
        ap_hit <= node_hit(haddr_i, married, logical_id);
      end
    end
  end

  assign test_wr  = wr_pend && ap_hit && (ap_ofs == `MSP_OFS_TEST_REPORT);
  assign clear_wr = wr_pend && ap_hit && (ap_ofs == `MSP_OFS_PROCESSOR_UNIT_CLEAR_COMMAND);
  assign state_wr = wr_pend && ap_hit && (ap_ofs == `MSP_OFS_STATE);
  assign msg_wr   = wr_pend && ap_hit && (ap_ofs == `MSP_OFS_MESSAGE);

  // Read data, unmapped offsets read zero
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= `MSP_RST_WORD;
    end else if (rd_pend) begin
      hrdata_o <= `MSP_RST_WORD;
      if (ap_hit) begin
        unique case (ap_ofs)
          `MSP_OFS_PROC_ID:    hrdata_o <= {24'h000000, proc_id};
          `MSP_OFS_LOGICAL_ID: hrdata_o <= {24'h000000, logical_id};
          `MSP_OFS_PARTNER_ID: hrdata_o <= {24'h000000, partner_id};
          `MSP_OFS_STATE:      hrdata_o <= {29'h00000000, active, shadow, married};
          `MSP_OFS_DEVICE_ID:  hrdata_o <= {24'h000000, PHYS_ID};
          `MSP_OFS_MESSAGE:    hrdata_o <= {31'h00000000, msg_pend};
          default:             hrdata_o <= `MSP_RST_WORD;
        endcase
      end
    end
  end

  // Identifier registers written by configuring software
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      proc_id    <= `MSP_RST_ID;
      logical_id <= PHYS_ID;
      partner_id <= `MSP_RST_ID;
    end else if (wr_pend && ap_hit) begin
      if (ap_ofs == `MSP_OFS_PROC_ID)    proc_id    <= hwdata_i[7:0];
      if (ap_ofs == `MSP_OFS_LOGICAL_ID) logical_id <= hwdata_i[7:0];
      if (ap_ofs == `MSP_OFS_PARTNER_ID) partner_id <= hwdata_i[7:0];
    end
  end

  // State bits; cleared at initialization
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      married <= 1'b0;
      shadow  <= 1'b0;
    end else if (state_wr) begin
      married <= hwdata_i[`MSP_STATE_MARRIED];
      shadow  <= hwdata_i[`MSP_STATE_SHADOW];
    end
  end

  // ----------------------------------------------------------------
  // Active / passive role
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active <= 1'b1;
    end else if (state_wr) begin
      // Marrying: primary active, shadow passive; unmarried all active
      active <= !hwdata_i[`MSP_STATE_MARRIED] || !hwdata_i[`MSP_STATE_SHADOW];
    end else if (married && seq == msp_pkg::MSP_ISSUE && bus_grant_i) begin
      active <= !active;
    end
  end

  // ----------------------------------------------------------------
  // Retry line: pin synchroniser and local test report
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rs1  <= 1'b0;
      rs2  <= 1'b0;
      rs3  <= 1'b0;
      rlvl <= 1'b0;
    end else begin
      rs1 <= retry_all_i;
      rs2 <= rs1;
      rs3 <= rs2;
      if (rs2 == rs3) rlvl <= rs3;
    end
  end

  assign retry_evt = ((rs2 == rs3) && rs3 && !rlvl) || test_wr;

  // Broadcast pulse to all other units
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) retry_all_o <= 1'b0;
    else         retry_all_o <= test_wr;
  end

  // ----------------------------------------------------------------
  // Access sequencer, identical in both members of a pair
  // ----------------------------------------------------------------
  assign reissue = bus_err_i || retry_evt;
  assign proc_ready_o = (seq == msp_pkg::MSP_IDLE);
  assign rb.load     = proc_ready_o && proc_req_i;
  assign rb.addr_in  = proc_addr_i;
  assign rb.wr_in    = proc_wr_i;
  assign rb.wdata_in = proc_wdata_i;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq <= msp_pkg::MSP_IDLE;
    end else begin
      unique case (seq)
        msp_pkg::MSP_IDLE:  if (proc_req_i) seq <= msp_pkg::MSP_ISSUE;
        msp_pkg::MSP_ISSUE: if (bus_grant_i) seq <= msp_pkg::MSP_WAIT;
        msp_pkg::MSP_WAIT: begin
          if (reissue)         seq <= msp_pkg::MSP_ISSUE;
          else if (bus_done_i) seq <= msp_pkg::MSP_IDLE;
        end
        default: seq <= msp_pkg::MSP_IDLE;
      endcase
    end
  end

  // Bus address, direction and write data come straight from the held buffer
  assign bus_req_o    = (seq == msp_pkg::MSP_ISSUE);
  assign bus_arb_id_o = logical_id;
  assign bus_addr_o   = rb.addr;
  assign bus_wr_o     = rb.wr;
  assign bus_wdata_o  = rb.wdata;
  assign bus_oe_o     = active && (seq != msp_pkg::MSP_IDLE);

  // Inbound data taken by both members
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      proc_done_o  <= 1'b0;
      proc_rdata_o <= `MSP_RST_WORD;
    end else begin
      proc_done_o <= (seq == msp_pkg::MSP_WAIT) && bus_done_i && !reissue;
      if ((seq == msp_pkg::MSP_WAIT) && bus_done_i && !reissue)
        proc_rdata_o <= bus_rdata_i;
    end
  end

  msp_retry_buf u_rb (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .rb        (rb)
  );

  // ----------------------------------------------------------------
  // Processor clear output
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)           clr_cnt <= 4'h0;
    else if (clear_wr)     clr_cnt <= 4'(`MSP_CLEAR_CYCLES);
    else if (clr_cnt != 4'h0) clr_cnt <= clr_cnt - 4'h1;
  end

  assign processor_clear_output_o = (clr_cnt != 4'h0);

  // ----------------------------------------------------------------
  // Interprocessor messages
  // ----------------------------------------------------------------
  assign ipc_accept_o = ipc_valid_i && (ipc_target_i == proc_id);

  // Pending flag: a new message wins over a software clear
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)           msg_pend <= 1'b0;
    else if (ipc_accept_o) msg_pend <= 1'b1;
    else if (msg_wr)       msg_pend <= 1'b0;
  end

  // Start-up hands the processor identifier to the processor
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      proc_id_o      <= `MSP_RST_ID;
      proc_id_load_o <= 1'b0;
    end else begin
      proc_id_load_o <= ipc_accept_o && ipc_startup_i;
      if (ipc_accept_o && ipc_startup_i) proc_id_o <= proc_id;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_clear_write;
    clear_wr;
  endsequence

  sequence s_clear_pulse;
    processor_clear_output_o [*8] ##1 processor_clear_output_o ##1 processor_clear_output_o;
  endsequence

  a_clear_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_clear_write |=> s_clear_pulse)
    else $error("processor clear pulse too short");

  a_err_reissue: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (seq == msp_pkg::MSP_WAIT) && bus_err_i |=> bus_req_o && $stable(bus_addr_o))
    else $error("transient error did not reissue");

  a_cap_same: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rb.load |=> bus_req_o && bus_addr_o == $past(proc_addr_i))
    else $error("request not issued from buffer next cycle");

  a_test_retry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    test_wr && (seq == msp_pkg::MSP_WAIT) |=> retry_all_o && bus_req_o)
    else $error("test report did not retry");

  a_passive_quiet: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    married && !active |-> !bus_oe_o)
    else $error("passive unit drives bus");

  a_role_swap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    married && !state_wr && bus_req_o && bus_grant_i |=> active != $past(active))
    else $error("roles did not swap");

  a_ipc_match: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ipc_accept_o && ipc_startup_i |=> proc_id_load_o && proc_id_o == $past(proc_id))
    else $error("start-up did not supply processor id");

  a_decode_married: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ap_take && married && haddr_i[15:8] != logical_id |=> !ap_hit)
    else $error("married unit decoded physical id");

  a_unmarry_active: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    state_wr && !hwdata_i[`MSP_STATE_MARRIED] |=> active && !married)
    else $error("unmarried unit not active");

endmodule : msp_top

`default_nettype wire

/* File: verification/msp_bus_model.sv */
// Memory bus responder on the far side of the pairing block
`timescale 1ns/1ps
`default_nettype none

module msp_bus_model (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        bus_req_i,
  input  wire logic [31:0] bus_addr_i,
  input  wire logic        slow_i,
  input  wire logic        err_once_i,
  output logic             grant_o,
  output logic             done_o,
  output logic             err_o,
  output logic [31:0]      rdata_o
);
  logic [1:0]  phase;
  logic [3:0]  cnt;
  logic        err_used;
  logic [31:0] data;

  // Released data lines show the inverse of the last word
  assign rdata_o = done_o ? data : ~data;

  // Grant after a delay, then finish, or fail once on command
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase    <= 2'h0;
      cnt      <= 4'h0;
      err_used <= 1'b0;
      data     <= 32'h0;
      grant_o  <= 1'b0;
      done_o   <= 1'b0;
      err_o    <= 1'b0;
    end else begin
      grant_o <= 1'b0;
      done_o  <= 1'b0;
      err_o   <= 1'b0;
      if (!err_once_i) err_used <= 1'b0;
      case (phase)
        2'h0: if (bus_req_i) begin
          cnt   <= slow_i ? 4'h3 : 4'h0;
          phase <= 2'h1;
        end
        2'h1: if (cnt != 4'h0) cnt <= cnt - 4'h1;
        else begin
          grant_o <= 1'b1;
          cnt     <= slow_i ? 4'h8 : 4'h1;
          phase   <= 2'h2;
        end
        default: if (cnt != 4'h0) cnt <= cnt - 4'h1;
        else begin
          if (err_once_i && !err_used) begin
            err_o    <= 1'b1;
            err_used <= 1'b1;
          end else begin
            done_o <= 1'b1;
            data   <= bus_addr_i ^ 32'h5a5a_0000;
          end
          phase <= 2'h0;
        end
      endcase
    end
  end
endmodule : msp_bus_model

`default_nettype wire

/* File: verification/test_module_shadow_pairing_control.sv */
// Self-checking bench for the shadow pairing control block
`timescale 1ns/1ps
`default_nettype none
`include "msp_defs.svh"

module test_module_shadow_pairing_control;
  localparam msp_pkg::msp_id_t PID = 8'h21; // Arbitrary value
  localparam msp_pkg::msp_id_t LID = 8'h40;

  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        preq = 1'b0, pwr = 1'b0, proc_ready, proc_done, pclr, pid_load;
  logic [31:0] paddr = 32'h0, pwd = 32'h0, proc_rdata;
  logic [7:0]  proc_id, bus_arb_id, ipc_t = 8'h0;
  logic        ipc_v = 1'b0, ipc_s = 1'b0, ipc_acc;
  logic        bus_req, bus_wr, bus_oe, grant, done, err;
  logic [31:0] bus_addr, bus_wdata, rdata;
  logic        retry_in = 1'b0, retry_out, slow = 1'b0, err1 = 1'b0;
  int          fails = 0;
  int          num_checks = 0;

  // ----------------------------------------------------------------
  // Clock, design and bus partner
  // ----------------------------------------------------------------
  always #5 ref_clk_i = ~ref_clk_i;

  msp_top #(.PHYS_ID(PID)) i_msp_top (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .proc_req_i(preq), .proc_addr_i(paddr), .proc_wr_i(pwr), .proc_wdata_i(pwd),
    .proc_ready_o(proc_ready), .proc_done_o(proc_done), .proc_rdata_o(proc_rdata),
    .processor_clear_output_o(pclr), .proc_id_o(proc_id), .proc_id_load_o(pid_load),
    .ipc_valid_i(ipc_v), .ipc_target_i(ipc_t), .ipc_startup_i(ipc_s),
    .ipc_accept_o(ipc_acc), .bus_req_o(bus_req), .bus_arb_id_o(bus_arb_id),
    .bus_addr_o(bus_addr), .bus_wr_o(bus_wr), .bus_wdata_o(bus_wdata), .bus_oe_o(bus_oe),
    .bus_grant_i(grant), .bus_done_i(done), .bus_err_i(err), .bus_rdata_i(rdata),
    .retry_all_i(retry_in), .retry_all_o(retry_out));

  msp_bus_model i_msp_bus_model (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_req_i(bus_req), .bus_addr_i(bus_addr),
    .slow_i(slow), .err_once_i(err1), .grant_o(grant), .done_o(done), .err_o(err),
    .rdata_o(rdata));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // One single-word bus transfer, held until hready is seen high
  task automatic ahb(input logic [7:0] node, input logic [7:0] ofs, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {16'h0, node, ofs};
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  task automatic wr(input logic [7:0] node, input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] unused;
    ahb(node, ofs, 1'b1, d, unused);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] node, input logic [7:0] ofs,
                     input logic [31:0] exp);
    logic [31:0] got;
    ahb(node, ofs, 1'b0, 32'h0, got);
    chk(nm, exp, got);
  endtask : rdc

  // Processor access; content changes right after capture
  task automatic acc(input logic [31:0] a, input logic w, input logic s, input logic e,
                     input logic ra, input logic oe, input int ng);
    int g;
    int n;
    g = 0;
    @(posedge ref_clk_i);
    preq <= 1'b1;
    paddr <= a;
    pwr <= w;
    pwd <= ~a;
    slow <= s;
    err1 <= e;
    @(posedge ref_clk_i);
    preq <= 1'b0;
    paddr <= ~a;
    pwd <= a;
    #1;
    chk("bus_req", 32'h1, {31'h0, bus_req});
    chk("bus_addr", a, bus_addr);
    chk("bus_wdata", ~a, bus_wdata);
    chk("bus_oe", {31'h0, oe}, {31'h0, bus_oe});
    for (n = 0; n < 100 && proc_done !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      if (ra && g > 0) retry_in <= 1'b1;
      #1;
      if (grant === 1'b1) g++;
    end
    @(posedge ref_clk_i);
    retry_in <= 1'b0;
    err1 <= 1'b0;
    chk("grants", ng, g);
    chk("bus_addr kept", a, bus_addr);
    chk("bus_wr", {31'h0, w}, {31'h0, bus_wr});
    if (!w) chk("proc_rdata", a ^ 32'h5a5a_0000, proc_rdata);
  endtask : acc

  // Count cycles in which the retry pulse or the clear output is high
  task automatic count_hi(input logic sel, input int span, input int exp);
    int c;
    c = 0;
    repeat (span) begin
      #1;
      if ((sel ? pclr : retry_out) === 1'b1) c++;
      @(posedge ref_clk_i);
    end
    chk(sel ? "clear cycles" : "retry pulses", exp, c);
  endtask : count_hi

  // ----------------------------------------------------------------
  // Watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    report_and_stop;
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rdc("state", PID, `MSP_OFS_STATE, 32'h4);
    rdc("proc id", PID, `MSP_OFS_PROC_ID, {24'h0, `MSP_RST_ID});
    rdc("device id", PID, `MSP_OFS_DEVICE_ID, {24'h0, PID});
    rdc("unmapped", PID, 8'h20, 32'h0);
    chk("arb id", {24'h0, PID}, {24'h0, bus_arb_id});
    $display("test reset done");
    acc(32'h0000_1000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1);
    acc(32'h0000_2004, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2);
    acc(32'h0000_3008, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 2);
    wr(PID, `MSP_OFS_TEST_REPORT, 32'hdead_beef);
    count_hi(1'b0, 5, 1);
    // Test report lands while a slow access waits for completion
    fork
      acc(32'h0000_7000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2);
      begin
        repeat (6) @(posedge ref_clk_i);
        wr(PID, `MSP_OFS_TEST_REPORT, 32'h0);
      end
    join
    $display("test retry done");
    wr(PID, `MSP_OFS_PROC_ID, 32'h33);
    @(posedge ref_clk_i);
    ipc_v <= 1'b1;
    ipc_t <= 8'h33;
    #1 chk("accept match", 32'h1, {31'h0, ipc_acc});
    @(posedge ref_clk_i);
    ipc_t <= 8'h34;
    #1 chk("accept other", 32'h0, {31'h0, ipc_acc});
    @(posedge ref_clk_i);
    ipc_t <= 8'h33;
    ipc_s <= 1'b1;
    @(posedge ref_clk_i);
    ipc_v <= 1'b0;
    ipc_s <= 1'b0;
    #1 chk("id load", 32'h1, {31'h0, pid_load});
    chk("proc id out", 32'h33, {24'h0, proc_id});
    rdc("msg pending", PID, `MSP_OFS_MESSAGE, 32'h1);
    wr(PID, `MSP_OFS_MESSAGE, 32'h0);
    rdc("msg cleared", PID, `MSP_OFS_MESSAGE, 32'h0);
    wr(PID, `MSP_OFS_PROCESSOR_UNIT_CLEAR_COMMAND, 32'h0);
    count_hi(1'b1, 20, `MSP_CLEAR_CYCLES);
    $display("test messages done");
    wr(PID, `MSP_OFS_LOGICAL_ID, {24'h0, LID});
    #1 chk("arb id logical", {24'h0, LID}, {24'h0, bus_arb_id});
    wr(PID, `MSP_OFS_PARTNER_ID, 32'h55);
    rdc("partner id", PID, `MSP_OFS_PARTNER_ID, 32'h55);
    wr(PID, `MSP_OFS_STATE, 32'h1);
    rdc("state by phys", PID, `MSP_OFS_STATE, 32'h0);
    rdc("state by logical", LID, `MSP_OFS_STATE, 32'h5);
    acc(32'h0000_4000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1);
    rdc("role after request", LID, `MSP_OFS_STATE, 32'h1);
    acc(32'h0000_5000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    rdc("role swapped back", LID, `MSP_OFS_STATE, 32'h5);
    wr(LID, `MSP_OFS_STATE, 32'h3);
    rdc("shadow passive", LID, `MSP_OFS_STATE, 32'h3);
    acc(32'h0000_6000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    wr(LID, `MSP_OFS_STATE, 32'h0);
    rdc("unmarried", PID, `MSP_OFS_STATE, 32'h4);
    chk("arb id kept", {24'h0, LID}, {24'h0, bus_arb_id});
    $display("test pairing done");
    report_and_stop;
  end
endmodule : test_module_shadow_pairing_control

`default_nettype wire
